//--- design/arft_pkg.sv
// Package: register map, field layout and trigger codes for the result block
package arft_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_TRIG   = 8'h00;
    localparam logic [7:0] ADDR_JUSTIFY     = 8'h04;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'h0C;
    localparam logic [7:0] ADDR_STATUS      = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         TRIG_SEL_LSB    = 3;
    localparam int         TRIG_SEL_W      = 5;
    localparam int         TRIG_NUM        = 32;
    localparam logic [4:0] TRIG_SEL_RESET  = 5'h00;
    localparam logic [4:0] TRIG_NONE       = 5'h00;
    localparam logic [4:0] TRIG_RESERVED   = 5'h1F;
    localparam logic [4:0] TRIG_TMR1_OVF   = 5'h04;
    localparam logic [4:0] TRIG_LAST_VALID = 5'h14;
    localparam logic       JUSTIFY_RESET   = 1'b0;
    localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;

    // ------------------------------------------------------------
    // Conversion result from the sequencer
    // ------------------------------------------------------------
    typedef struct packed {
        logic       done;
        logic [9:0] value;
    } arft_result_t;

    // AHB-Lite address phase held for the data phase
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
    } arft_ahb_phase_t;

endpackage : arft_pkg

//--- design/arft_result_format_trigger.sv
// Result justification, auto-trigger selection and AHB-Lite register file
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Left justify: result bits 9..2 go to high result byte bits 7..0.
// - Left justify: result bits 1..0 go to low result byte bits 7..6.
// - Left justify: low byte bits 5..0 reserved, software must ignore them.
// - Right justify: result bits 9..8 to high byte bits 1..0; rest reserved.
// - Right justify: result bits 7..0 go to low result byte bits 7..0.
// - Result bytes software read/write; unknown at power-on, kept by resets.
// - Timer one overflow trigger also sets its own interrupt flag.
// - Five-bit trigger select in control bits 7..3; codes 0x15 to all-ones reserved.
module arft_result_format_trigger
    import arft_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic               hsel,
    input  wire logic               hready,
    input  wire logic [31:0]        hwdata,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic [TRIG_NUM-1:0] triggerIn,
    input  wire arft_result_t       convResult,
    output logic                    autoStart,
    output logic                    timerOneOverflowFlag,
    output logic                    resultJustifySelect
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic trigUsable(input logic [4:0] sel);
        trigUsable = (sel != TRIG_NONE) && (sel <= TRIG_LAST_VALID);
    endfunction : trigUsable

    function automatic logic [15:0] justify(input logic [9:0] v,
                                            input logic       right);
        if (right)
            justify = {6'h00, v[9:8], v[7:0]};
        else
            justify = {v[9:2], v[1:0], 6'h00};
    endfunction : justify

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    arft_ahb_phase_t            phaseReg, phaseNext;
    logic [4:0]                 trigSelReg, trigSelNext;
    logic                       justifyReg, justifyNext;
    logic [7:0]                 resHighReg, resHighNext;
    logic [7:0]                 resLowReg, resLowNext;
    logic [TRIG_NUM-1:0]        trigSync1Reg, trigSync2Reg, trigPrevReg;
    logic                       startReg, startNext;
    logic                       t1FlagReg, t1FlagNext;
    logic [31:0]                rdataReg, rdataNext;
    logic                       doneSync1Reg, doneSync2Reg, donePrevReg;
    logic [9:0]                 valSync1Reg, valSync2Reg;
    logic                       selEdge, t1Edge, doneEdge;
    logic [15:0]                placed;
    logic                       hreadyReg, hreadyNext;
    logic                       hrespReg, hrespNext;
    logic                       flagClear;

    assign hreadyout            = hreadyReg;
    assign hresp                = hrespReg;
    assign hrdata               = rdataReg;
    assign autoStart            = startReg;
    assign timerOneOverflowFlag = t1FlagReg;
    assign resultJustifySelect  = justifyReg;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        phaseNext.addr  = haddr[7:0];
        phaseNext.write = hsel && hready && htrans[1] && hwrite;
        phaseNext.read  = hsel && hready && htrans[1] && !hwrite;
        trigSelNext = trigSelReg;
        justifyNext = justifyReg;
        resHighNext = resHighReg;
        resLowNext  = resLowReg;
        rdataNext   = rdataReg;
        hreadyNext  = 1'b1;
        hrespNext   = 1'b0;
        // Rising edge on the selected source only
        selEdge  = trigUsable(trigSelReg) &&
                   trigSync2Reg[trigSelReg] && !trigPrevReg[trigSelReg];
        t1Edge   = trigSync2Reg[TRIG_TMR1_OVF] &&
                   !trigPrevReg[TRIG_TMR1_OVF];
        doneEdge = doneSync2Reg && !donePrevReg;
        startNext  = selEdge;
        t1FlagNext = t1FlagReg;
        flagClear  = phaseReg.write && (phaseReg.addr == ADDR_STATUS) &&
                     hwdata[0];
        placed = justify(valSync2Reg, justifyReg);
        if (doneEdge) begin
            resHighNext = placed[15:8];
            resLowNext  = placed[7:0];
        end
        if (phaseReg.write) begin
            case (phaseReg.addr)
                ADDR_CTRL_TRIG:   trigSelNext = hwdata[7:3];
                ADDR_JUSTIFY:     justifyNext = hwdata[0];
                ADDR_RESULT_HIGH: if (!doneEdge) resHighNext = hwdata[7:0];
                ADDR_RESULT_LOW:  if (!doneEdge) resLowNext = hwdata[7:0];
                ADDR_STATUS:      if (hwdata[0]) t1FlagNext = 1'b0;
                default:          ;
            endcase
        end
        if (t1Edge)
            t1FlagNext = 1'b1;
        if (phaseNext.read) begin
            case (haddr[7:0])
                ADDR_CTRL_TRIG:   rdataNext = {24'h0, trigSelReg, 3'h0};
                ADDR_JUSTIFY:     rdataNext = {31'h0, justifyReg};
                ADDR_RESULT_HIGH: rdataNext = {24'h0, resHighReg};
                ADDR_RESULT_LOW:  rdataNext = {24'h0, resLowReg};
                ADDR_STATUS:      rdataNext = {31'h0, t1FlagReg};
                default:          rdataNext = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        trigSync1Reg <= triggerIn;
        trigSync2Reg <= trigSync1Reg;
        trigPrevReg  <= trigSync2Reg;
        doneSync1Reg <= convResult.done;
        doneSync2Reg <= doneSync1Reg;
        donePrevReg  <= doneSync2Reg;
        valSync1Reg  <= convResult.value;
        valSync2Reg  <= valSync1Reg;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        resHighReg   <= resHighNext;
        resLowReg    <= resLowNext;
        rdataReg     <= rdataNext;
        if (sys_rst) begin
            phaseReg    <= '0;
            trigSelReg  <= TRIG_SEL_RESET;
            justifyReg  <= JUSTIFY_RESET;
            startReg    <= 1'b0;
            t1FlagReg   <= 1'b0;
            hreadyReg   <= 1'b1;
            hrespReg    <= 1'b0;
        end else begin
            phaseReg    <= phaseNext;
            trigSelReg  <= trigSelNext;
            justifyReg  <= justifyNext;
            startReg    <= startNext;
            t1FlagReg   <= t1FlagNext;
            hreadyReg   <= hreadyNext;
            hrespReg    <= hrespNext;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_no_reserved_start: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        !trigUsable($past(trigSelReg)) |-> !startReg)
        else $error("start from unusable trigger select");

    chk_start_on_edge: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        startReg |-> $past(trigSync2Reg[trigSelReg]))
        else $error("start without selected trigger high");

    chk_left_high: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        doneEdge && !justifyReg && !phaseReg.write |=>
        resHighReg == $past(valSync2Reg[9:2]))
        else $error("left high byte wrong");

    chk_left_low: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        doneEdge && !justifyReg |=>
        resLowReg == {$past(valSync2Reg[1:0]), 6'h00})
        else $error("left low byte wrong");

    chk_right_high: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        doneEdge && justifyReg |=>
        resHighReg == {6'h00, $past(valSync2Reg[9:8])})
        else $error("right high byte wrong");

    chk_right_low: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        doneEdge && justifyReg |=> resLowReg == $past(valSync2Reg[7:0]))
        else $error("right low byte wrong");

    chk_timer_flag: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        t1Edge |=> timerOneOverflowFlag ##1
        (timerOneOverflowFlag || $past(flagClear)))
        else $error("timer one flag not set");

    chk_result_kept: assert property (@(posedge ref_clk)
        $rose(sys_rst) |=> $stable(resHighReg) && $stable(resLowReg))
        else $error("result changed by reset");

    chk_select_write: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        phaseReg.write && phaseReg.addr == ADDR_CTRL_TRIG |=>
        trigSelReg == $past(hwdata[7:3]))
        else $error("trigger select not written");

    chk_start_single: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        startReg && $stable(trigSelReg) |=> !startReg)
        else $error("start held for more than one cycle");

    chk_start_needs_edge: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        startReg |-> !$past(trigPrevReg[trigSelReg]))
        else $error("start without a rising edge");

    chk_edge_starts: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        trigUsable(trigSelReg) && trigSync2Reg[trigSelReg] &&
        !trigPrevReg[trigSelReg] |=> autoStart)
        else $error("selected rising edge gave no start");

    chk_flag_sticky: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        timerOneOverflowFlag && !flagClear |=> timerOneOverflowFlag)
        else $error("timer one flag dropped without clear");

    chk_flag_source: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        !timerOneOverflowFlag && !t1Edge |=> !timerOneOverflowFlag)
        else $error("timer one flag set without event");

    chk_flag_clear: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        flagClear && !t1Edge |=> !timerOneOverflowFlag)
        else $error("timer one flag not cleared");

    chk_high_write: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        phaseReg.write && phaseReg.addr == ADDR_RESULT_HIGH && !doneEdge |=>
        resHighReg == $past(hwdata[7:0]))
        else $error("high result byte not written");

    chk_low_write: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        phaseReg.write && phaseReg.addr == ADDR_RESULT_LOW && !doneEdge |=>
        resLowReg == $past(hwdata[7:0]))
        else $error("low result byte not written");

    chk_result_steady: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        !doneEdge && !phaseReg.write |=>
        $stable(resHighReg) && $stable(resLowReg))
        else $error("result changed without capture or write");

    chk_reserved_left: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        doneEdge && !justifyReg |=> resLowReg[5:0] == 6'h00)
        else $error("left low reserved bits not clear");

    chk_reserved_right: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        doneEdge && justifyReg |=> resHighReg[7:2] == 6'h00)
        else $error("right high reserved bits not clear");

    chk_ctrl_readback: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        hsel && hready && htrans[1] && !hwrite &&
        haddr[7:0] == ADDR_CTRL_TRIG |=>
        hrdata == {24'h000000, $past(trigSelReg), 3'h0})
        else $error("control read data wrong");

    chk_low_readback: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        hsel && hready && htrans[1] && !hwrite &&
        haddr[7:0] == ADDR_RESULT_LOW |=>
        hrdata == {24'h000000, $past(resLowReg)})
        else $error("low result read data wrong");

    chk_select_kept: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        !(phaseReg.write && phaseReg.addr == ADDR_CTRL_TRIG) |=>
        $stable(trigSelReg))
        else $error("trigger select changed without write");

    chk_justify_write: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        phaseReg.write && phaseReg.addr == ADDR_JUSTIFY |=>
        resultJustifySelect == $past(hwdata[0]))
        else $error("justify select not written");

endmodule : arft_result_format_trigger

`default_nettype wire

//--- test/arft_result_format_trigger_bench.sv
// Bench: register access, result justification and trigger selection
`timescale 1ns/10ps
`default_nettype none
module arft_result_format_trigger_bench
    import arft_pkg::*;
;
    logic         ref_clk, sys_rst, hwrite, hsel, hreadyout, hresp;
    logic         autoStart, timerOneOverflowFlag, resultJustifySelect;
    logic [31:0]  haddr, hwdata, hrdata, triggerIn, r;
    logic [1:0]   htrans;
    arft_result_t convResult;
    int           fails, compares, s0;
    int           starts = 0;
    logic [9:0]   vals [2] = '{10'h2B5, 10'h14E};
    logic [4:0]   codes [6] = '{5'h01, 5'h04, 5'h14, 5'h15, 5'h1F, 5'h00};

    arft_result_format_trigger u_arft_result_format_trigger (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hsel(hsel), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .triggerIn(triggerIn), .convResult(convResult),
        .autoStart(autoStart), .timerOneOverflowFlag(timerOneOverflowFlag),
        .resultJustifySelect(resultJustifySelect));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) if (autoStart === 1'b1) starts <= starts + 1;

    task automatic stop_test;
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask : waitRdy

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        haddr  <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsel   <= 1'b1;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask : bus

    task automatic convert(input logic [9:0] v);
        convResult.value <= v;
        repeat (2) @(posedge ref_clk);
        convResult.done <= 1'b1;
        repeat (4) @(posedge ref_clk);
        convResult.done <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : convert

    task automatic pulse(input int idx, input int exp);
        s0 = starts;
        triggerIn <= 32'h00000001 << idx;
        repeat (8) @(posedge ref_clk);
        triggerIn <= 32'h00000000;
        repeat (4) @(posedge ref_clk);
        chk("autoStart count", 32'(starts - s0), 32'(exp));
    endtask : pulse

    initial begin
        sys_rst    = 1'b1;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsel       = 1'b0;
        hwdata     = 32'h0;
        triggerIn  = 32'h0;
        convResult = '0;
        fails      = 0;
        compares   = 0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, ADDR_CTRL_TRIG, 32'h0, r);
        chk("ctrl", r, 32'h0);
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, ADDR_JUSTIFY, 32'(j), r);
            convert(vals[j]);
            chk("justify", {31'h0, resultJustifySelect}, 32'(j));
            bus(1'b0, ADDR_RESULT_HIGH, 32'h0, r);
            chk("high", r, j ? {30'h0, vals[j][9:8]}
                             : {24'h0, vals[j][9:2]});
            bus(1'b0, ADDR_RESULT_LOW, 32'h0, r);
            chk("low", r, j ? {24'h0, vals[j][7:0]}
                            : {24'h0, vals[j][1:0], 6'h00});
        end
        bus(1'b1, ADDR_RESULT_HIGH, 32'h0000005A, r);
        bus(1'b1, ADDR_RESULT_LOW, 32'h000000C3, r);
        bus(1'b1, ADDR_CTRL_TRIG, 32'h00000050, r);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, ADDR_RESULT_HIGH, 32'h0, r);
        chk("high kept", r, 32'h5A);
        bus(1'b0, ADDR_RESULT_LOW, 32'h0, r);
        chk("low kept", r, 32'hC3);
        bus(1'b0, ADDR_CTRL_TRIG, 32'h0, r);
        chk("ctrl reset", r, 32'h0);
        bus(1'b0, 8'h20, 32'h0, r);
        chk("unmapped", r, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        foreach (codes[i]) begin
            bus(1'b1, ADDR_CTRL_TRIG, {24'h0, codes[i], 3'h7}, r);
            bus(1'b0, ADDR_CTRL_TRIG, 32'h0, r);
            chk("trig sel", r, {24'h0, codes[i], 3'h0});
            pulse(int'(codes[i]),
                  (codes[i] >= 5'h01 && codes[i] <= 5'h14));
        end
        bus(1'b0, ADDR_STATUS, 32'h0, r);
        chk("flag set", r, 32'h1);
        chk("flag pin set", {31'h0, timerOneOverflowFlag}, 32'h1);
        bus(1'b1, ADDR_STATUS, 32'h1, r);
        bus(1'b0, ADDR_STATUS, 32'h0, r);
        chk("flag clr", r, 32'h0);
        chk("flag pin clr", {31'h0, timerOneOverflowFlag}, 32'h0);
        pulse(4, 0);
        bus(1'b0, ADDR_STATUS, 32'h0, r);
        chk("flag alone", r, 32'h1);
        stop_test();
    end
endmodule : arft_result_format_trigger_bench
`default_nettype wire
